// ===== logic/mps_map.svh
// named constants of the monitor power and operating-state control block
// assumes a 20 MHz core clock; included by bare name from the link, core and bench files
// Notes on behaviour
// - sleep plus link wake-up goes to standby
// - sleep: reference, converters off, watchdog expired
// - core asleep holds serial link idle
// - conversion or keep-on: settle, then warm/measure
// - standby sleeps after quiet time, timers expired
// - discharge timer disabled: watchdog alone decides
// - warm state only after keep-on config write
// - warm: reference on, conversion enters measure
// - keep-on cleared: warm returns to standby
// - conversions done: warm if keep-on, else standby
// - only conversion or diagnostic commands start measure
// - watchdog expiry after 2 s releases pin
// - discharge timer needs soft-timer enable strap high
// - port A wake: link idle to ready, timed
// - link ready falls idle after 5.5 ms quiet
// - link ready goes active while transferring data
// - mode strap high isolated pulses, low SPI
// - port B only on daisy-chain variant
// - addressable variant drops addressed commands for other chips
// - host drives select, clock, data; SDO open-drain
// - link startup within 10 us from standby
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH

`define MPS_CLK_KHZ 20000
`define MPS_WDOG_TIME_MS 2000
`define MPS_WDOG_CYC (`MPS_WDOG_TIME_MS * `MPS_CLK_KHZ)
`define MPS_SLEEP_TIME_MS 1800
`define MPS_SLEEP_CYC (`MPS_SLEEP_TIME_MS * `MPS_CLK_KHZ)
`define MPS_DIS_TIME_MS 1000
`define MPS_DIS_CYC (`MPS_DIS_TIME_MS * `MPS_CLK_KHZ)
`define MPS_LINK_IDLE_TIME_US 5500
`define MPS_LINK_IDLE_CYC ((`MPS_LINK_IDLE_TIME_US * `MPS_CLK_KHZ + 999) / 1000)
`define MPS_READY_TIME_US 10
`define MPS_READY_CYC (`MPS_READY_TIME_US * `MPS_CLK_KHZ / 1000)
`define MPS_WAKE_TIME_US 400
`define MPS_WAKE_CYC (`MPS_WAKE_TIME_US * `MPS_CLK_KHZ / 1000)
`define MPS_SETTLE_TIME_US 100
`define MPS_SETTLE_CYC ((`MPS_SETTLE_TIME_US * `MPS_CLK_KHZ + 999) / 1000)

`define MPS_CMD_BITS 8
`define MPS_CMD_OP_HI 7
`define MPS_CMD_OP_LO 6
`define MPS_OP_OTHER 2'h0
`define MPS_OP_CONV 2'h1
`define MPS_OP_DIAG 2'h2
`define MPS_OP_CFGW 2'h3
`define MPS_CMD_ADDRD 5
`define MPS_CMD_ADDR_HI 4
`define MPS_CMD_ADDR_LO 1
`define MPS_CMD_REFERENCE_KEEP_ON 0
`define MPS_BIT_LAST 3'h7
`define MPS_SYNC_STAGES 2'h2

`endif

// ===== logic/mps_pkg.sv
// state types of the monitor power and operating-state control block
// assumes nothing of its surroundings
package mps_pkg;
  typedef enum logic [2:0] {
    MPS_SLEEP = 3'h0,
    MPS_STANDBY = 3'h1,
    MPS_SETTLE = 3'h2,
    MPS_REFERENCE_WARM_STATE_WARM = 3'h3,
    MPS_MEASURE = 3'h4
  } mps_core_t;
  typedef enum logic [1:0] {
    MPS_IDLE = 2'h0,
    MPS_READY = 2'h1,
    MPS_ACTIVE = 2'h2
  } mps_link_t;
endpackage

// ===== logic/mps_sync.sv
// two flip-flop level synchroniser, any width
// assumes each bit is a slow level or a toggle, never a multi-bit word
`timescale 1ns/1ps
module mps_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // first stage feeds the second stage only
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= '0;
      o_q <= '0;
    end else if (i_ce) begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// ===== logic/mps_link.sv
// serial front end on the link clock: takes the first byte of each frame as a command
// assumes the link clock runs only inside frames; one command per frame
`timescale 1ns/1ps
`include "mps_map.svh"
module mps_link (
  input wire logic i_link_clk,
  input wire logic i_reset,
  input wire logic i_iso_mode,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_pa_frame_n,
  input wire logic i_pa_data,
  output logic [`MPS_CMD_BITS-1:0] o_cmd,
  output logic o_cmd_tgl,
  output logic o_sdo,
  output logic o_sdo_oe_n
);
  logic iso_s;
  logic frame_n;
  logic din;
  logic [2:0] bit_cnt_q;
  logic first_q;
  logic [`MPS_CMD_BITS-1:0] shift_q;
  logic sdo_rel_q;
  logic frame_clr;

  // mode strap is a level from the core domain
  mps_sync #(.W(1)) u_iso_sync (
    .i_clk(i_link_clk),
    .i_reset(i_reset),
    .i_ce(1'b1),
    .i_d(i_iso_mode),
    .o_q(iso_s)
  );

  // isolated port A pulses or plain SPI pins feed one receiver
  assign frame_n = iso_s ? i_pa_frame_n : i_cs_n;
  assign din = iso_s ? i_pa_data : i_sdi;

  // the link clock stands still between frames, so the end of a frame clears the bit count at once
  assign frame_clr = i_reset | frame_n;

  always_ff @(posedge i_link_clk or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt_q <= 3'h0;
      first_q <= 1'b1;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == `MPS_BIT_LAST) begin
        first_q <= 1'b0;
      end
    end
  end

  // shift in msb first on rising link clock; the command word stays put until the next frame
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      shift_q <= '0;
      o_cmd <= '0;
      o_cmd_tgl <= 1'b0;
    end else if (!frame_n) begin
      shift_q <= {shift_q[`MPS_CMD_BITS-2:0], din};
      if (bit_cnt_q == `MPS_BIT_LAST && first_q) begin
        o_cmd <= {shift_q[`MPS_CMD_BITS-2:0], din};
        o_cmd_tgl <= ~o_cmd_tgl;
      end
    end
  end

  // echo the last command on SDO; a one releases the open-drain pin
  always_ff @(posedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      sdo_rel_q <= 1'b1;
    end else begin
      sdo_rel_q <= frame_n | o_cmd[`MPS_BIT_LAST - bit_cnt_q];
    end
  end

  // chip select ends the drive by itself, since no clock edge follows a frame
  assign o_sdo = 1'b0;
  assign o_sdo_oe_n = sdo_rel_q | i_cs_n | iso_s;
endmodule

// ===== logic/mps_core.sv
// core and serial-link state machines of a stackable battery monitor
// assumes i_clk is the internal oscillator; link pins arrive on i_link_clk or asynchronously
`timescale 1ns/1ps
`include "mps_map.svh"
module mps_core
  import mps_pkg::*;
#(
  parameter int WDOG_CYC = `MPS_WDOG_CYC,
  parameter int SLEEP_CYC = `MPS_SLEEP_CYC,
  parameter int DIS_CYC = `MPS_DIS_CYC,
  parameter int LINK_IDLE_CYC = `MPS_LINK_IDLE_CYC,
  parameter int WAKE_CYC = `MPS_WAKE_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_link_clk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_pa_frame_n,
  input wire logic i_pa_data,
  input wire logic i_port_a_wake,
  input wire logic i_port_b_busy,
  input wire logic i_interface_mode_strap,
  input wire logic i_soft_timer_enable_pin,
  input wire logic i_variant_addressable,
  input wire logic [3:0] i_chip_addr_straps,
  input wire logic i_conv_done,
  input wire logic i_discharge_start,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  output logic o_watchdog_output,
  output logic o_watchdog_output_oe_n,
  output logic o_ref_on,
  output logic o_adc_on,
  output logic [2:0] o_core_state,
  output logic [1:0] o_link_state,
  output logic o_port_a_en,
  output logic o_port_b_en,
  output logic o_iso_mode,
  output logic o_reference_keep_on,
  output logic o_discharge_running
);
  localparam int SYNC_W = 11;
  localparam int ready_bound = `MPS_READY_CYC + 2;

  mps_core_t core_q;
  mps_core_t core_d;
  mps_link_t link_q;
  mps_link_t link_d;
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] async_s;
  logic [`MPS_CMD_BITS-1:0] cmd_w;
  logic cmd_tgl;
  logic wake_s;
  logic b_busy_s;
  logic frame_s;
  logic tgl_s;
  logic tgl_seen_q;
  logic straps_done_q;
  logic [1:0] strap_wait_q;
  logic iso_q;
  logic soft_timer_enable_pin_q;
  logic addrv_q;
  logic [3:0] addr_q;
  logic cmd_ev;
  logic cmd_mine;
  logic [1:0] cmd_op;
  logic conv_acc;
  logic cfg_wr;
  logic [31:0] quiet_q;
  logic [31:0] wdog_cnt_q;
  logic wdog_exp_q;
  logic wdog_hit;
  logic [31:0] dis_cnt_q;
  logic dis_run_q;
  logic sleep_ok;
  logic ref_keep_on_q;
  logic meas_pend_q;
  logic [15:0] settle_cnt_q;
  logic start_pend_q;
  logic [15:0] start_cnt_q;
  logic link_busy;
  logic [15:0] settle_len_q;

  // serial receiver on the link's own clock
  mps_link u_link (
    .i_link_clk(i_link_clk),
    .i_reset(i_reset),
    .i_iso_mode(iso_q),
    .i_cs_n(i_cs_n),
    .i_sdi(i_sdi),
    .i_pa_frame_n(i_pa_frame_n),
    .i_pa_data(i_pa_data),
    .o_cmd(cmd_w),
    .o_cmd_tgl(cmd_tgl),
    .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n)
  );

  // every strap, wake, busy and link-domain level enters through two flops
  assign async_in = {cmd_tgl, ~(i_interface_mode_strap ? i_pa_frame_n : i_cs_n), i_chip_addr_straps,
                     i_variant_addressable, i_soft_timer_enable_pin, i_interface_mode_strap,
                     i_port_b_busy, i_port_a_wake};

  mps_sync #(.W(SYNC_W)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_d(async_in),
    .o_q(async_s)
  );

  assign wake_s = async_s[0];
  assign b_busy_s = async_s[1];
  assign frame_s = async_s[9];
  assign tgl_s = async_s[10];

  // straps are caught once after reset release, so a later wiggle cannot change the mode;
  // the capture waits until the synchroniser has flushed its reset zeros
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      strap_wait_q <= 2'h0;
      straps_done_q <= 1'b0;
      iso_q <= 1'b0;
      soft_timer_enable_pin_q <= 1'b0;
      addrv_q <= 1'b0;
      addr_q <= 4'h0;
    end else if (i_ce && !straps_done_q) begin
      if (strap_wait_q != `MPS_SYNC_STAGES) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end else begin
        straps_done_q <= 1'b1;
        iso_q <= async_s[2];
        soft_timer_enable_pin_q <= async_s[3];
        addrv_q <= async_s[4];
        addr_q <= async_s[8:5];
      end
    end
  end

  // command arrival: toggle edge; the word has been stable since well before it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tgl_seen_q <= 1'b0;
    end else if (i_ce) begin
      tgl_seen_q <= tgl_s;
    end
  end

  assign cmd_ev = (tgl_s != tgl_seen_q) && straps_done_q;
  assign cmd_op = cmd_w[`MPS_CMD_OP_HI:`MPS_CMD_OP_LO];
  // addressable part drops addressed commands meant for another chip
  assign cmd_mine = !(addrv_q && cmd_w[`MPS_CMD_ADDRD] &&
                      (cmd_w[`MPS_CMD_ADDR_HI:`MPS_CMD_ADDR_LO] != addr_q));
  // only conversion and diagnostic opcodes reach the measure path
  assign conv_acc = cmd_ev && cmd_mine && (cmd_op == `MPS_OP_CONV || cmd_op == `MPS_OP_DIAG);
  assign cfg_wr = cmd_ev && cmd_mine && (cmd_op == `MPS_OP_CFGW);

  // quiet time since the last wake-up, saturating; shared by sleep and link idle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      quiet_q <= 32'h0;
    end else if (i_ce) begin
      if (wake_s) begin
        quiet_q <= 32'h0;
      end else if (quiet_q != 32'hFFFFFFFF) begin
        quiet_q <= quiet_q + 32'h1;
      end
    end
  end

  // watchdog: restarted by wake-up, starts expired so power-up lands in sleep
  assign wdog_hit = !wdog_exp_q && !wake_s && (wdog_cnt_q == 32'(WDOG_CYC - 1));

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wdog_cnt_q <= 32'h0;
      wdog_exp_q <= 1'b1;
    end else if (i_ce) begin
      if (wake_s) begin
        wdog_cnt_q <= 32'h0;
        wdog_exp_q <= 1'b0;
      end else if (wdog_hit) begin
        wdog_exp_q <= 1'b1;
      end else if (!wdog_exp_q) begin
        wdog_cnt_q <= wdog_cnt_q + 32'h1;
      end
    end
  end

  // open-drain watchdog pin pulls low while running, floats once expired
  assign o_watchdog_output = 1'b0;
  assign o_watchdog_output_oe_n = wdog_exp_q;

  // discharge timer only runs when the soft-timer strap enabled it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dis_cnt_q <= 32'h0;
      dis_run_q <= 1'b0;
    end else if (i_ce) begin
      if (i_discharge_start && soft_timer_enable_pin_q) begin
        dis_cnt_q <= 32'h0;
        dis_run_q <= 1'b1;
      end else if (dis_run_q && dis_cnt_q == 32'(DIS_CYC - 1)) begin
        dis_run_q <= 1'b0;
      end else if (dis_run_q) begin
        dis_cnt_q <= dis_cnt_q + 32'h1;
      end
    end
  end

  // a disabled discharge timer never runs, so the watchdog alone decides
  assign sleep_ok = (quiet_q >= 32'(SLEEP_CYC)) && wdog_exp_q && (!soft_timer_enable_pin_q || !dis_run_q);

  // keep-on bit: config write sets or clears, watchdog expiry clears; a write of one wins
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ref_keep_on_q <= 1'b0;
    end else if (i_ce) begin
      if (cfg_wr) begin
        ref_keep_on_q <= cmd_w[`MPS_CMD_REFERENCE_KEEP_ON];
      end else if (wdog_hit) begin
        ref_keep_on_q <= 1'b0;
      end
    end
  end

  // a conversion asked for during settling is remembered for its end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meas_pend_q <= 1'b0;
    end else if (i_ce) begin
      if (core_q == MPS_SETTLE && core_d != MPS_SETTLE) begin
        meas_pend_q <= 1'b0;
      end else if (conv_acc && (core_q == MPS_STANDBY || core_q == MPS_SETTLE)) begin
        meas_pend_q <= 1'b1;
      end
    end
  end

  // reference settle pause
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      settle_cnt_q <= 16'h0;
    end else if (i_ce) begin
      if (core_q != MPS_SETTLE) begin
        settle_cnt_q <= 16'h0;
      end else begin
        settle_cnt_q <= settle_cnt_q + 16'h1;
      end
    end
  end

  // core state machine
  always_comb begin
    core_d = core_q;
    unique case (core_q)
      MPS_SLEEP: begin
        if (wake_s) begin
          core_d = MPS_STANDBY;
        end
      end
      MPS_STANDBY: begin
        if (conv_acc || ref_keep_on_q) begin
          core_d = MPS_SETTLE;
        end else if (sleep_ok) begin
          core_d = MPS_SLEEP;
        end
      end
      MPS_SETTLE: begin
        if (settle_cnt_q == 16'(`MPS_SETTLE_CYC - 1)) begin
          core_d = (meas_pend_q || conv_acc) ? MPS_MEASURE : MPS_REFERENCE_WARM_STATE_WARM;
        end
      end
      MPS_REFERENCE_WARM_STATE_WARM: begin
        if (conv_acc) begin
          core_d = MPS_MEASURE;
        end else if (!ref_keep_on_q) begin
          core_d = MPS_STANDBY;
        end
      end
      MPS_MEASURE: begin
        if (i_conv_done) begin
          core_d = ref_keep_on_q ? MPS_REFERENCE_WARM_STATE_WARM : MPS_STANDBY;
        end
      end
      default: begin
        core_d = MPS_SLEEP;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      core_q <= MPS_SLEEP;
    end else if (i_ce) begin
      core_q <= core_d;
    end
  end

  // power controls follow the state; sleep and standby keep everything off
  assign o_ref_on = (core_q == MPS_SETTLE) || (core_q == MPS_REFERENCE_WARM_STATE_WARM) || (core_q == MPS_MEASURE);
  assign o_adc_on = (core_q == MPS_MEASURE);

  // link startup delay: short from standby, long when the core was asleep
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      start_pend_q <= 1'b0;
      start_cnt_q <= 16'h0;
    end else if (i_ce) begin
      if (link_q == MPS_IDLE && wake_s && !start_pend_q) begin
        start_pend_q <= 1'b1;
        start_cnt_q <= (core_q == MPS_SLEEP) ? 16'(WAKE_CYC - 1) : 16'(`MPS_READY_CYC - 1);
      end else if (core_q == MPS_SLEEP) begin
        start_pend_q <= 1'b0; // a startup cut short by sleep must not leave a stale ready
      end else if (start_pend_q && start_cnt_q != 16'h0) begin
        start_cnt_q <= start_cnt_q - 16'h1;
      end else if (link_q != MPS_IDLE) begin
        start_pend_q <= 1'b0;
      end
    end
  end

  // port B traffic only counts on the daisy-chain part
  assign link_busy = frame_s || (b_busy_s && !addrv_q);

  // serial-link state machine
  always_comb begin
    link_d = link_q;
    unique case (link_q)
      MPS_IDLE: begin
        if (start_pend_q && start_cnt_q == 16'h0) begin
          link_d = MPS_READY;
        end
      end
      MPS_READY: begin
        if (link_busy) begin
          link_d = MPS_ACTIVE;
        end else if (quiet_q >= 32'(LINK_IDLE_CYC)) begin
          link_d = MPS_IDLE;
        end
      end
      MPS_ACTIVE: begin
        if (!link_busy) begin
          link_d = MPS_READY;
        end
      end
      default: begin
        link_d = MPS_IDLE;
      end
    endcase
    if (core_q == MPS_SLEEP) begin
      link_d = MPS_IDLE;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      link_q <= MPS_IDLE;
    end else if (i_ce) begin
      link_q <= link_d;
    end
  end

  // status outputs
  assign o_core_state = core_q;
  assign o_link_state = link_q;
  assign o_port_a_en = (link_q != MPS_IDLE);
  assign o_port_b_en = (link_q != MPS_IDLE) && !addrv_q;
  assign o_iso_mode = iso_q;
  assign o_reference_keep_on = ref_keep_on_q;
  assign o_discharge_running = dis_run_q;

  // helper: length of each settle pause, read only by the checks below
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      settle_len_q <= 16'h0;
    end else if (i_ce) begin
      settle_len_q <= (core_q == MPS_SETTLE) ? settle_len_q + 16'h1 : 16'h0;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_wake_from_standby;
    link_q == MPS_IDLE && wake_s && core_q == MPS_STANDBY && !start_pend_q && i_ce;
  endsequence

  sequence s_link_up;
    link_q == MPS_READY;
  endsequence

  sleep_wake_a: assert property (core_q == MPS_SLEEP && wake_s && i_ce |=> core_q == MPS_STANDBY)
    else $error("sleep did not wake to standby");
  sleep_power_a: assert property (core_q == MPS_SLEEP |-> !o_ref_on && !o_adc_on && wdog_exp_q)
    else $error("power or watchdog wrong in sleep");
  sleep_link_a: assert property (core_q == MPS_SLEEP && i_ce |=> link_q == MPS_IDLE)
    else $error("link not idle while core sleeps");
  settle_len_a: assert property (core_q == MPS_SETTLE && i_ce && core_d != MPS_SETTLE
    |-> settle_len_q == 16'(`MPS_SETTLE_CYC - 1))
    else $error("reference settle pause has wrong length");
  reference_warm_state_meas_a: assert property (core_q == MPS_REFERENCE_WARM_STATE_WARM && conv_acc && i_ce |=> core_q == MPS_MEASURE)
    else $error("warm state ignored conversion");
  reference_warm_state_exit_a: assert property (core_q == MPS_REFERENCE_WARM_STATE_WARM && !ref_keep_on_q && !conv_acc && i_ce
    |=> core_q == MPS_STANDBY)
    else $error("warm state kept without keep-on bit");
  meas_done_a: assert property (core_q == MPS_MEASURE && i_conv_done && i_ce
    |=> core_q == ($past(ref_keep_on_q) ? MPS_REFERENCE_WARM_STATE_WARM : MPS_STANDBY))
    else $error("wrong state after conversions");
  meas_cause_a: assert property (core_q == MPS_MEASURE && $past(core_q) != MPS_MEASURE
    |-> $past(conv_acc) || $past(meas_pend_q))
    else $error("measure entered without conversion command");
  wdog_expire_a: assert property (wdog_hit && i_ce && !cfg_wr |=> wdog_exp_q && !ref_keep_on_q
    && o_watchdog_output_oe_n)
    else $error("watchdog expiry not acted on");
  ready_time_a: assert property (s_wake_from_standby |-> ##[1:ready_bound] s_link_up)
    else $error("link startup from standby too slow");
  link_idle_a: assert property (link_q == MPS_READY && !link_busy && quiet_q >= 32'(LINK_IDLE_CYC)
    && i_ce |=> link_q == MPS_IDLE)
    else $error("link stayed ready after idle timeout");
  link_active_a: assert property (link_q == MPS_READY && link_busy && core_q != MPS_SLEEP && i_ce
    |=> link_q == MPS_ACTIVE)
    else $error("link did not go active on traffic");
  port_b_a: assert property (o_port_b_en |-> !addrv_q && o_port_a_en)
    else $error("port B enabled on addressable part");
endmodule

// ===== sim/mps_host.sv
// host-side model of the 4-wire serial link: frames one command byte
// assumes the device samples data on the rising link clock, msb first
`timescale 1ns/1ps
module mps_host (
  output logic o_link_clk,
  output logic o_cs_n,
  output logic o_sdi
);
  initial begin
    o_link_clk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // link clock runs only inside a frame, 12 ns period, stands low outside
  task automatic send(input logic [7:0] b);
    o_cs_n = 1'b0;
    #30;
    for (int i = 7; i >= 0; i--) begin
      o_sdi = b[i];
      #6 o_link_clk = 1'b1;
      #6 o_link_clk = 1'b0;
    end
    #30;
    o_cs_n = 1'b1;
    // released data line shows the inverse so no stale bit is trusted
    o_sdi = ~o_sdi;
  endtask
endmodule

// ===== sim/monitor_power_state_control_tb_top.sv
// self-checking bench of the power and operating-state control block
// assumes the host model of mps_host.sv and shortened timer parameters
`timescale 1ns/1ps
`include "mps_map.svh"
module monitor_power_state_control_tb_top;
  import mps_pkg::*;
  localparam int WDOG = 64;
  localparam int SLP = 32;
  localparam int SETTLE = 2000;
  localparam int DIS = 150;
  localparam int LIDLE = 48;
  localparam int WAKE = 300;
  logic i_clk, i_reset, wake, busy, conv_done, dis_start, pa_data;
  logic ce, iso_strap, soft_timer_enable_pin, addrv;
  logic link_clk, cs_n, sdi, sdo, sdo_oe_n, wdt, wdt_oe_n, ref_on, adc_on;
  logic pa_en, pb_en, iso, keep_on, dis_run;
  logic [3:0] addr;
  logic [2:0] core;
  logic [1:0] link;
  logic [31:0] rnd;
  int miscompares, checks_done, cyc, model_keep;

  mps_host i_host (.o_link_clk(link_clk), .o_cs_n(cs_n), .o_sdi(sdi));
  // straps start as spi mode, daisy chain, no discharge timer; a later reset turns the timer on
  mps_core #(.WDOG_CYC(WDOG), .SLEEP_CYC(SLP), .DIS_CYC(DIS), .LINK_IDLE_CYC(LIDLE), .WAKE_CYC(WAKE)) i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_link_clk(link_clk), .i_cs_n(cs_n), .i_sdi(sdi),
    .i_pa_frame_n(1'b1), .i_pa_data(pa_data), .i_port_a_wake(wake), .i_port_b_busy(busy),
    .i_interface_mode_strap(iso_strap), .i_soft_timer_enable_pin(soft_timer_enable_pin), .i_variant_addressable(addrv),
    .i_chip_addr_straps(addr), .i_conv_done(conv_done), .i_discharge_start(dis_start),
    .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_watchdog_output(wdt), .o_watchdog_output_oe_n(wdt_oe_n),
    .o_ref_on(ref_on), .o_adc_on(adc_on), .o_core_state(core), .o_link_state(link), .o_port_a_en(pa_en),
    .o_port_b_en(pb_en), .o_iso_mode(iso), .o_reference_keep_on(keep_on), .o_discharge_running(dis_run));

  always #25 i_clk = ~i_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // unused isolated data line gets a changing pattern, never a stale level
  always @(negedge i_clk) begin
    rnd <= lfsr(rnd);
    pa_data <= rnd[0];
  end

  task automatic report(input string what, input logic [7:0] got, input logic [7:0] exp);
    miscompares++;
    $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
  endtask
  task automatic chk_core(input logic [2:0] e);
    checks_done++;
    if (core !== e) report("core", core, e);
  endtask
  task automatic chk_link(input logic [1:0] e);
    checks_done++;
    if (link !== e) report("link", link, e);
  endtask
  task automatic chk_bit(input logic b, input logic e);
    checks_done++;
    if (b !== e) report("flag", b, e);
  endtask
  // bounded waits: give up after lim cycles, then compare anyway
  task automatic wait_core(input logic [2:0] e, input int lim);
    for (int n = 0; n < lim && core !== e; n++) @(negedge i_clk);
    chk_core(e);
  endtask
  task automatic wait_link(input logic [1:0] e, input int lim);
    for (int n = 0; n < lim && link !== e; n++) @(negedge i_clk);
    chk_link(e);
  endtask
  // model keeps the keep-on bit as the host last wrote it
  task automatic cmd(input logic [1:0] op, input logic kon);
    if (op == `MPS_OP_CFGW) model_keep = kon;
    i_host.send({op, 1'b0, addr, kon});
    @(negedge i_clk);
    chk_bit(sdo_oe_n, 1'b1);
  endtask
  // settle must last about its full time, neither much shorter nor much longer
  task automatic settle_then(input logic [2:0] e);
    wait_core(MPS_SETTLE, 6);
    repeat (SETTLE - 10) @(negedge i_clk);
    chk_core(MPS_SETTLE);
    wait_core(e, 20);
  endtask
  task automatic conv_end;
    conv_done = 1'b1;
    @(negedge i_clk);
    conv_done = 1'b0;
    wait_core(model_keep ? MPS_REFERENCE_WARM_STATE_WARM : MPS_STANDBY, 3);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  initial begin
    i_clk = 1'b0;
    i_reset = 1'b1;
    wake = 1'b0;
    busy = 1'b0;
    conv_done = 1'b0;
    dis_start = 1'b0;
    ce = 1'b1;
    iso_strap = 1'b0;
    soft_timer_enable_pin = 1'b0;
    addrv = 1'b0;
    rnd = 32'h3EA5;
    pa_data = 1'b0;
    addr = rnd[4:1];
    model_keep = 0;
    repeat (4) @(negedge i_clk);
    i_reset = 1'b0;
    chk_core(MPS_SLEEP);
    chk_link(MPS_IDLE);
    chk_bit(wdt_oe_n, 1'b1);
    chk_bit(ref_on | adc_on, 1'b0);
    chk_bit(sdo | wdt | ~sdo_oe_n, 1'b0);
    repeat (4) @(negedge i_clk);
    chk_bit(iso, 1'b0);
    $display("reset test done");
    wake = 1'b1;
    wait_core(MPS_STANDBY, 5);
    chk_bit(wdt_oe_n, 1'b0);
    wait_link(MPS_READY, 310);
    chk_bit(pa_en & pb_en, 1'b1);
    busy = 1'b1;
    wait_link(MPS_ACTIVE, 5);
    busy = 1'b0;
    $display("wake test done");
    cmd(`MPS_OP_OTHER, 1'b0);
    repeat (6) @(negedge i_clk);
    chk_core(MPS_STANDBY);
    cmd(`MPS_OP_CONV, 1'b0);
    settle_then(MPS_MEASURE);
    chk_bit(ref_on & adc_on, 1'b1);
    conv_end;
    cmd(`MPS_OP_CFGW, 1'b1);
    settle_then(MPS_REFERENCE_WARM_STATE_WARM);
    chk_bit(ref_on & ~adc_on & keep_on, 1'b1);
    // a low clock enable holds the warm state and the pending command until it returns
    ce = 1'b0;
    cmd(`MPS_OP_CONV, 1'b0);
    repeat (4) @(negedge i_clk);
    chk_core(MPS_REFERENCE_WARM_STATE_WARM);
    ce = 1'b1;
    wait_core(MPS_MEASURE, 6);
    conv_end;
    cmd(`MPS_OP_DIAG, 1'b0);
    wait_core(MPS_MEASURE, 6);
    conv_end;
    cmd(`MPS_OP_CONV, 1'b0);
    wait_core(MPS_MEASURE, 6);
    conv_end;
    cmd(`MPS_OP_CFGW, 1'b0);
    wait_core(MPS_STANDBY, 6);
    $display("command test done");
    dis_start = 1'b1;
    @(negedge i_clk);
    dis_start = 1'b0;
    @(negedge i_clk);
    chk_bit(dis_run, 1'b0);
    wake = 1'b0;
    repeat (40) @(negedge i_clk);
    chk_core(MPS_STANDBY);
    chk_link(MPS_READY);
    chk_bit(wdt_oe_n, 1'b0);
    wait_link(MPS_IDLE, 20);
    wait_core(MPS_SLEEP, WDOG + SLP);
    chk_bit(wdt_oe_n, 1'b1);
    chk_bit(pa_en | pb_en, 1'b0);
    $display("quiet test done");
    // second reset with the discharge timer strapped on: sleep waits for both timers
    soft_timer_enable_pin = 1'b1;
    i_reset = 1'b1;
    repeat (4) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    chk_core(MPS_SLEEP);
    wake = 1'b1;
    wait_core(MPS_STANDBY, 5);
    dis_start = 1'b1;
    @(negedge i_clk);
    dis_start = 1'b0;
    wake = 1'b0;
    chk_bit(dis_run, 1'b1);
    repeat (100) @(negedge i_clk);
    chk_core(MPS_STANDBY);
    chk_bit(wdt_oe_n, 1'b1);
    wait_core(MPS_SLEEP, DIS);
    chk_bit(dis_run, 1'b0);
    $display("discharge test done");
    tally_and_finish;
  end
endmodule
